/* common/remap_event_regs.vh */
// Register offsets, field positions and reset values of the remap register slice.
`ifndef REMAP_EVENT_REGS_VH
`define REMAP_EVENT_REGS_VH

`define OFS_EVT_DATA 8'hA4
`define OFS_ADDR_LOW 8'hA8
`define OFS_ADDR_HIGH 8'hAC
`define OFS_TBL_LO 8'hB8
`define OFS_TBL_HI 8'hBC
`define OFS_EVT_CTRL 8'hA0
`define OFS_CACHE_CMD 8'hC0
`define OFS_CACHE_STAT 8'hC4

`define LOW_ADDR_LSB 2
`define DWM_BIT 11
`define TSIZE_MSB 3
`define TBASE_LSB 12
`define DATA_MSB 15
`define MASK_BIT 31
`define PEND_BIT 30
`define RESET_MASK 1'b1
`define ZERO32 32'h00000000
`define CMD_CTX 0
`define CMD_TRANS 1
`define CMD_IEC 2
`define CMD_WBF 3
`define FLUSH_CYCLES 4'h4

`endif

/* verilog/write_buffer_flush.v */
// Write-buffer flush sequencer run ahead of every cache invalidation.
`timescale 1ns/1ps
module write_buffer_flush #(
	parameter CYCLES = 4
) (
	// Clock and reset.
	input wire sys_clk,
	input wire sys_rst,
	// Request and completion.
	input wire start,
	input wire required,
	output reg done
);
	reg [7:0] countReg;
	reg busyReg;

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			countReg <= 8'h00;
			busyReg <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !busyReg) begin
				if (required) begin
					busyReg <= 1'b1;
					countReg <= CYCLES[7:0];
				end else begin
					done <= 1'b1;
				end
			end else if (busyReg) begin
				if (countReg == 8'h01) begin
					busyReg <= 1'b0;
					done <= 1'b1;
				end
				countReg <= countReg - 8'h01;
			end
		end
	end
endmodule

/* verilog/dest_id_mask.v */
// Destination identifier width selection for table entries.
`timescale 1ns/1ps
module dest_id_mask (
	// Mode and raw identifier.
	input wire wideMode,
	input wire [31:0] rawDest,
	// Interpreted identifier.
	output wire [31:0] effDest
);
	assign effDest = wideMode ? rawDest : {24'h000000, rawDest[7:0]};
endmodule

/* verilog/remap_event_and_table_regs.v */
// APB register slice for invalidation event address and remap table base.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "remap_event_regs.vh"
module remap_event_and_table_regs #(
	parameter HOST_ADDR_WIDTH = 39,
	parameter FLUSH_CYCLES = 4
) (
	// Clock and reset.
	input wire sys_clk,
	input wire sys_rst,
	// APB slave.
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Capabilities.
	input wire queued_invalidation_capability,
	input wire extended_destination_capability,
	input wire interrupt_remap_capability,
	input wire write_buffer_flush_required,
	// Invalidation event source.
	input wire invalDone,
	// Entry destination lookup.
	input wire [31:0] entryDest,
	output reg [31:0] destOut,
	// Event interrupt write.
	output reg msgValid,
	output reg [63:0] msgAddr,
	output reg [31:0] msgData,
	input wire msgAccept,
	// Cache invalidation requests.
	output reg [3:0] invalReq,
	// Table configuration to remap logic.
	output reg [63:0] tableBase,
	output reg [16:0] tableEntries
);
	// ----------------------------------------------------------------
	// Capability and invalidation event synchronisers.
	// ----------------------------------------------------------------
	reg [3:0] capMeta;
	reg [3:0] capSync;
	reg invMeta;
	reg invSync;
	reg invSyncD;
	wire queCap = capSync[0];
	wire extCap = capSync[1];
	wire remapCap = capSync[2];
	wire wbfReq = capSync[3];

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			capMeta <= 4'h0;
			capSync <= 4'h0;
			invMeta <= 1'b0;
			invSync <= 1'b0;
			invSyncD <= 1'b0;
		end else begin
			capMeta <= {write_buffer_flush_required,
				interrupt_remap_capability,
				extended_destination_capability,
				queued_invalidation_capability};
			capSync <= capMeta;
			invMeta <= invalDone;
			invSync <= invMeta;
			invSyncD <= invSync;
		end
	end

	// ----------------------------------------------------------------
	// Register storage.
	// ----------------------------------------------------------------
	reg [29:0] lowAddrReg;
	reg [31:0] highAddrReg;
	reg [15:0] dataReg;
	reg maskReg;
	reg pendReg;
	reg [51:0] baseReg;
	reg dwmReg;
	reg [3:0] sizeReg;
	reg [3:0] cmdReg;
	reg flushBusyReg;
	reg flushStart;
	wire flushDone;

	wire access = psel && penable;
	wire wr = access && pwrite;
	wire evtSet = invSync && !invSyncD;
	wire msgFire = msgValid && msgAccept;

	function [63:0] baseMask;
		input integer host_address_width;
		integer i;
		begin
			baseMask = 64'h0000000000000000;
			for (i = 0; i < 64; i = i + 1) begin
				if (i < host_address_width)
					baseMask[i] = 1'b1;
			end
		end
	endfunction
	localparam [63:0] ADDR_MASK = baseMask(HOST_ADDR_WIDTH);

	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `OFS_EVT_DATA) || (a == `OFS_ADDR_LOW) ||
				(a == `OFS_ADDR_HIGH) || (a == `OFS_TBL_LO) ||
				(a == `OFS_TBL_HI) || (a == `OFS_EVT_CTRL) ||
				(a == `OFS_CACHE_CMD) || (a == `OFS_CACHE_STAT);
		end
	endfunction

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			lowAddrReg <= 30'h00000000;
			highAddrReg <= `ZERO32;
			dataReg <= 16'h0000;
			maskReg <= `RESET_MASK;
			baseReg <= 52'h0000000000000;
			dwmReg <= 1'b0;
			sizeReg <= 4'h0;
			cmdReg <= 4'h0;
			flushBusyReg <= 1'b0;
			flushStart <= 1'b0;
		end else begin
			flushStart <= 1'b0;
			if (wr && queCap && paddr == `OFS_ADDR_LOW)
				lowAddrReg <= pwdata[31:`LOW_ADDR_LSB];
			if (wr && queCap && extCap && paddr == `OFS_ADDR_HIGH)
				highAddrReg <= pwdata;
			if (wr && queCap && paddr == `OFS_EVT_DATA)
				dataReg <= pwdata[`DATA_MSB:0];
			if (wr && queCap && paddr == `OFS_EVT_CTRL)
				maskReg <= pwdata[`MASK_BIT];
			if (wr && remapCap && paddr == `OFS_TBL_LO) begin
				baseReg[19:0] <= pwdata[31:`TBASE_LSB];
				dwmReg <= pwdata[`DWM_BIT] & extCap;
				sizeReg <= pwdata[`TSIZE_MSB:0];
			end
			if (wr && remapCap && paddr == `OFS_TBL_HI)
				baseReg[51:20] <= pwdata & ADDR_MASK[63:32];
			if (wr && paddr == `OFS_CACHE_CMD && !flushBusyReg &&
				pwdata[3:0] != 4'h0) begin
				cmdReg <= pwdata[3:0];
				flushBusyReg <= 1'b1;
				flushStart <= 1'b1;
			end else if (flushDone) begin
				flushBusyReg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Flush ahead of invalidation.
	// ----------------------------------------------------------------
	write_buffer_flush #(
		.CYCLES(FLUSH_CYCLES)
	) flushUnit (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.start(flushStart),
		.required(wbfReq),
		.done(flushDone)
	);

	always @(posedge sys_clk) begin
		if (sys_rst)
			invalReq <= 4'h0;
		else if (flushDone)
			invalReq <= cmdReg;
		else
			invalReq <= 4'h0;
	end

	// ----------------------------------------------------------------
	// Event interrupt message.
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			pendReg <= 1'b0;
			msgValid <= 1'b0;
			msgAddr <= 64'h0000000000000000;
			msgData <= `ZERO32;
		end else begin
			if (evtSet && queCap)
				pendReg <= 1'b1;
			else if (msgFire)
				pendReg <= 1'b0;
			if (msgFire)
				msgValid <= 1'b0;
			else if (pendReg && !maskReg && !msgValid) begin
				msgValid <= 1'b1;
				msgAddr <= {highAddrReg, lowAddrReg, 2'b00};
				msgData <= {16'h0000, dataReg};
			end
		end
	end

	// ----------------------------------------------------------------
	// Table configuration outputs.
	// ----------------------------------------------------------------
	wire [31:0] effDest;
	dest_id_mask destUnit (
		.wideMode(dwmReg),
		.rawDest(entryDest),
		.effDest(effDest)
	);

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			destOut <= `ZERO32;
			tableBase <= 64'h0000000000000000;
			tableEntries <= 17'h00000;
		end else begin
			destOut <= effDest;
			tableBase <= {baseReg, 12'h000};
			tableEntries <= 17'h00002 << sizeReg;
		end
	end

	// ----------------------------------------------------------------
	// APB read and response.
	// ----------------------------------------------------------------
	reg [31:0] rdNext;
	always @* begin
		rdNext = `ZERO32;
		case (paddr)
		`OFS_EVT_DATA: rdNext = queCap ? {16'h0000, dataReg} : `ZERO32;
		`OFS_EVT_CTRL: rdNext = queCap ? {maskReg, pendReg, 30'h0} : `ZERO32;
		`OFS_ADDR_LOW: rdNext = queCap ? {lowAddrReg, 2'b00} : `ZERO32;
		`OFS_ADDR_HIGH: rdNext = highAddrReg;
		`OFS_TBL_LO: rdNext = remapCap ?
			{baseReg[19:0], dwmReg, 7'h00, sizeReg} : `ZERO32;
		`OFS_TBL_HI: rdNext = remapCap ? baseReg[51:20] : `ZERO32;
		`OFS_CACHE_CMD: rdNext = {28'h0000000, cmdReg};
		`OFS_CACHE_STAT: rdNext = {31'h00000000, flushBusyReg};
		default: rdNext = `ZERO32;
		endcase
	end

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			prdata <= `ZERO32;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped(paddr);
			if (psel && !penable)
				prdata <= rdNext;
		end
	end
endmodule

/* tb/remap_regs_sva.sv */
// Port assertions for the remap register slice.
`timescale 1ns/1ps
module remap_regs_sva #(
	parameter HOST_ADDR_WIDTH = 39
) (
	// Clock and reset.
	input wire sys_clk,
	input wire sys_rst,
	// Bus handshake.
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	// Event write.
	input wire msgValid,
	input wire msgAccept,
	input wire [63:0] msgAddr,
	input wire [31:0] msgData,
	// Table outputs.
	input wire [63:0] tableBase,
	input wire [16:0] tableEntries
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence setupS;
		psel && !penable;
	endsequence
	ready_follows_a: assert property (setupS |=> pready)
		else $error("no ready after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready too long");
	err_needs_ready_a: assert property (pslverr |-> pready)
		else $error("lone error");
	addr_aligned_a: assert property (msgAddr[1:0] == 2'h0)
		else $error("event address unaligned");
	base_aligned_a: assert property (tableBase[11:0] == 12'h000)
		else $error("table base unaligned");
	base_width_a: assert property (tableBase[63:HOST_ADDR_WIDTH] == '0)
		else $error("table base too wide");
	entries_pow_a: assert property ($onehot0(tableEntries) &&
		!tableEntries[0])
		else $error("bad entry count");
	msg_hold_a: assert property (msgValid && !msgAccept |=>
		msgValid && $stable(msgAddr))
		else $error("event write dropped");
	data_width_a: assert property (msgData[31:16] == 16'h0000)
		else $error("event data too wide");
endmodule
bind remap_event_and_table_regs remap_regs_sva
	#(.HOST_ADDR_WIDTH(HOST_ADDR_WIDTH)) sva (
	.sys_clk, .sys_rst, .psel, .penable, .pready, .pslverr,
	.msgValid, .msgAccept, .msgAddr, .msgData, .tableBase, .tableEntries);

/* tb/tb_top.sv */
// Bench for the remap register slice.
`timescale 1ns/1ps
module tb_top;
	localparam int FC = 4;
	logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic queCap = 1, extCap = 1, remapCap = 1, flushCap = 1;
	logic invalDone = 0, msgAccept = 0, pready, pslverr, msgValid, rerr;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, entryDest = 0, prdata, destOut, msgData, rdat;
	logic [63:0] msgAddr, tableBase;
	logic [3:0] invalReq;
	logic [16:0] tableEntries;
	int n_fail = 0, checked = 0, cyc = 0, k;
	always #5 sys_clk = ~sys_clk;
	remap_event_and_table_regs #(.HOST_ADDR_WIDTH(39),
		.FLUSH_CYCLES(FC)) dut (
		.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr,
		.queued_invalidation_capability(queCap),
		.extended_destination_capability(extCap),
		.interrupt_remap_capability(remapCap),
		.write_buffer_flush_required(flushCap),
		.invalDone, .entryDest, .destOut, .msgValid, .msgAddr, .msgData,
		.msgAccept, .invalReq, .tableBase, .tableEntries);
	task final_report;
		$display("checks %0d fails %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [63:0] e, input logic [63:0] s);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		xfer(0, a, 0);
		chk(nm, e, rdat);
	endtask
	task waitMsg;
		for (k = 0; k < 20 && msgValid !== 1'b1; k++) @(posedge sys_clk);
	endtask
	// The flushed request must come no sooner than the flush takes, and sooner than that when no flush is required.
	task cmd(input logic slow, input logic [3:0] v);
		xfer(1, 8'hC0, {28'h0000000, v});
		for (k = 0; k < 30 && invalReq === 4'h0; k++) tick(1);
		chk("flush", {slow, 1'b1}, {k >= FC, k < 30});
		chk("ireq", v, invalReq);
		tick(20);
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			final_report;
		end
	end
	initial begin
		tick(16);
		sys_rst <= 0;
		tick(4);
		rd("ctl", 8'hA0, 32'h80000000);
		xfer(1, 8'hA8, '1);
		rd("lo", 8'hA8, 32'hFFFFFFFC);
		xfer(1, 8'hAC, 32'h12345678);
		rd("hi", 8'hAC, 32'h12345678);
		xfer(1, 8'hB8, '1);
		rd("tlo", 8'hB8, 32'hFFFFF80F);
		xfer(1, 8'hBC, '1);
		rd("thi", 8'hBC, 32'h7F);
		chk("base", 64'h7FFFFFF000, tableBase);
		chk("ent", 17'h10000, tableEntries);
		entryDest <= 32'hAABBCCDD;
		tick(3);
		chk("wide", 32'hAABBCCDD, destOut);
		xfer(1, 8'hB8, 32'h1002);
		tick(3);
		chk("narrow", 32'hDD, destOut);
		chk("ent", 17'h8, tableEntries);
		xfer(0, 8'h10, 0);
		chk("slverr", 1, rerr);
		xfer(1, 8'hA4, 32'h1234);
		xfer(1, 8'hA0, 0);
		invalDone <= 1;
		waitMsg;
		chk("maddr", 64'h12345678FFFFFFFC, msgAddr);
		chk("mdata", 32'h1234, msgData);
		msgAccept <= 1;
		tick(1);
		msgAccept <= 0;
		invalDone <= 0;
		xfer(1, 8'hA0, 32'h80000000);
		invalDone <= 1;
		tick(10);
		chk("masked", 0, msgValid);
		rd("pend", 8'hA0, 32'hC0000000);
		xfer(1, 8'hA0, 0);
		waitMsg;
		chk("unmask", 1, msgValid);
		msgAccept <= 1;
		tick(1);
		msgAccept <= 0;
		cmd(1, 4'h1);
		cmd(1, 4'h2);
		flushCap <= 0;
		tick(4);
		cmd(0, 4'h8);
		queCap <= 0;
		extCap <= 0;
		tick(4);
		xfer(1, 8'hA8, 32'h10);
		rd("noque", 8'hA8, 0);
		xfer(1, 8'hB8, 32'h800);
		rd("noext", 8'hB8, 0);
		remapCap <= 0;
		tick(4);
		rd("noremap", 8'hBC, 0);
		final_report;
	end
endmodule
